// [bench/tb_acr_top.sv]
// Self-checking bench for the converter configuration and result registers.
// Assumes acr_top on one 40 MHz pclk; the bench plays APB master and sequencer.
`default_nettype none

module tb_acr_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        conv_start = 1'b0;
  logic        conv_done = 1'b0;
  logic [9:0]  conv_result = 10'h000;
  logic        rc_tick = 1'b0;
  logic [2:0]  rc_cnt = 3'h0;
  logic        conv_tick;
  logic        conv_busy;
  logic [1:0]  reference_route;
  logic [2:0]  conversion_clock_select;
  int          err_total = 0;
  int          checks_done = 0;
  int          cycles = 0;

  acr_top acr_top_i (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .psel                    (psel),
    .penable                 (penable),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdata                  (pwdata),
    .pstrb                   (4'hF),
    .prdata                  (prdata),
    .pready                  (pready),
    .pslverr                 (pslverr),
    .conv_start              (conv_start),
    .conv_done               (conv_done),
    .conv_result             (conv_result),
    .rc_tick                 (rc_tick),
    .conv_tick               (conv_tick),
    .conv_busy               (conv_busy),
    .reference_route         (reference_route),
    .conversion_clock_select (conversion_clock_select)
  );

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  // The RC oscillator is modelled as a pulse every fifth cycle, so its interval differs from every divider.
  always @(posedge pclk) begin
    rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
    rc_tick <= (rc_cnt == 3'h4);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    checks_done++;
    if (seen !== expd) begin
      err_total++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask : check

  // Ready and read data are read right after a rising edge, before that edge's updates land,
  // so they are the values the edge sampled. Only the bench timeout ends a wait.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, wd, rd, err);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] expd);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    check(rd, expd);
  endtask : rd_chk

  task automatic pulse_start;
    @(posedge pclk);
    conv_start <= 1'b1;
    @(posedge pclk);
    conv_start <= 1'b0;
  endtask : pulse_start

  task automatic finish_conv(input logic [9:0] val);
    @(posedge pclk);
    conv_done <= 1'b1;
    conv_result <= val;
    @(posedge pclk);
    conv_done <= 1'b0;
    @(negedge pclk);
    check(32'(conv_busy), 32'h0000_0000);
  endtask : finish_conv

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_config;
    rd_chk(acr_pkg::CONFIG_ADDR, 32'h0000_0000);
    check(32'(reference_route), 32'h0000_0000);
    wr(acr_pkg::CONFIG_ADDR, 32'hFFFF_FFFF);
    rd_chk(acr_pkg::CONFIG_ADDR, 32'h0000_00F3);
    check(32'(conversion_clock_select), 32'h0000_0007);
    $display("test config done");
  endtask : test_config

  task automatic test_reference;
    logic [1:0] sel [3];
    sel = '{2'h0, 2'h2, 2'h3};
    foreach (sel[i]) begin
      wr(acr_pkg::CONFIG_ADDR, {30'h0000_0000, sel[i]});
      repeat (2) @(negedge pclk);
      check(32'(reference_route), 32'(sel[i]));
    end
    $display("test reference done");
  endtask : test_reference

  task automatic test_layout;
    wr(acr_pkg::CONFIG_ADDR, 32'h0000_0000);
    pulse_start();
    @(negedge pclk);
    check(32'(conv_busy), 32'h0000_0001);
    rd_chk(acr_pkg::STATUS_ADDR, 32'h0000_0002);
    finish_conv(10'h2D6);
    rd_chk(acr_pkg::STATUS_ADDR, 32'h0000_0000);
    rd_chk(acr_pkg::RES_HI_ADDR, 32'h0000_00B5);
    rd_chk(acr_pkg::RES_LO_ADDR, 32'h0000_0080);
    wr(acr_pkg::CONFIG_ADDR, 32'h0000_0080);
    pulse_start();
    finish_conv(10'h2D6);
    rd_chk(acr_pkg::RES_HI_ADDR, 32'h0000_0002);
    rd_chk(acr_pkg::RES_LO_ADDR, 32'h0000_00D6);
    $display("test layout done");
  endtask : test_layout

  task automatic test_keep;
    logic [31:0] rd;
    logic        err;
    wr(acr_pkg::CONFIG_ADDR, 32'h0000_00F3);
    wr(acr_pkg::RES_HI_ADDR, 32'h0000_005A);
    wr(acr_pkg::RES_LO_ADDR, 32'h0000_00A5);
    rd_chk(acr_pkg::RES_HI_ADDR, 32'h0000_005A);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(acr_pkg::RES_HI_ADDR, 32'h0000_005A);
    rd_chk(acr_pkg::RES_LO_ADDR, 32'h0000_00A5);
    rd_chk(acr_pkg::CONFIG_ADDR, 32'h0000_0000);
    check(32'(conversion_clock_select), 32'h0000_0000);
    check(32'(reference_route), 32'h0000_0000);
    apb(1'b1, 12'h010, 32'h0000_0080, rd, err);
    check(32'(err), 32'h0000_0001);
    rd_chk(acr_pkg::CONFIG_ADDR, 32'h0000_0000);
    $display("test keep done");
  endtask : test_keep

  // The gap between two ticks is measured, so the phase of the divider at start does not matter.
  task automatic test_clock;
    int div [8];
    int n;
    div = '{2, 8, 32, 5, 4, 16, 64, 5};
    for (int s = 0; s < 8; s++) begin
      wr(acr_pkg::CONFIG_ADDR, 32'(s) << 4);
      pulse_start();
      n = 0;
      @(negedge pclk);
      while (conv_tick !== 1'b1 && n < 200) begin
        n++;
        @(negedge pclk);
      end
      n = 1;
      @(negedge pclk);
      while (conv_tick !== 1'b1 && n < 200) begin
        n++;
        @(negedge pclk);
      end
      check(32'(n), 32'(div[s]));
      finish_conv(10'h155);
    end
    $display("test clock done");
  endtask : test_clock

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    test_config();
    test_reference();
    test_layout();
    test_keep();
    test_clock();
    give_verdict();
  end

endmodule : tb_acr_top

`default_nettype wire

// [verilog/acr_clock_divider.sv]
// Conversion clock enable generator.
// Assumes a select that changes only between conversions.
`default_nettype none

module acr_clock_divider (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] clock_select,
  input  wire logic       rc_tick,
  output logic            conv_tick
);

  logic [6:0] ratio;
  logic [6:0] count;

  always_comb begin
    case (clock_select)
      3'b000:  ratio = acr_pkg::DIV_2;
      3'b001:  ratio = acr_pkg::DIV_8;
      3'b010:  ratio = acr_pkg::DIV_32;
      3'b100:  ratio = acr_pkg::DIV_4;
      3'b101:  ratio = acr_pkg::DIV_16;
      3'b110:  ratio = acr_pkg::DIV_64;
      default: ratio = acr_pkg::DIV_RC;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count     <= 7'h00;
      conv_tick <= 1'b0;
    end else if (ratio == acr_pkg::DIV_RC) begin
      count     <= 7'h00;
      conv_tick <= rc_tick;
    end else if (count >= ratio - 7'h01) begin
      count     <= 7'h00;
      conv_tick <= 1'b1;
    end else begin
      count     <= count + 7'h01;
      conv_tick <= 1'b0;
    end
  end

  chk_rc_tick_follow : assert property (@(posedge pclk) disable iff (!presetn)
    (clock_select[1:0] == 2'b11) |=> (conv_tick == $past(rc_tick)))
    else $error("rc clock select does not pass the rc tick");

endmodule : acr_clock_divider

`default_nettype wire

// [verilog/acr_pkg.sv]
// Package for the converter configuration and result register block.
// Assumes a 32-bit APB master and a conversion sequencer on the same clock.
`default_nettype none

package acr_pkg;

  localparam int unsigned DATA_WIDTH   = 32;
  localparam int unsigned ADDR_WIDTH   = 12;
  localparam int unsigned RESULT_WIDTH = 10;
  localparam int unsigned CLKSEL_WIDTH = 3;

  // Byte addresses of the registers.
  localparam logic [11:0] CONFIG_ADDR  = 12'h000;
  localparam logic [11:0] RES_HI_ADDR  = 12'h004;
  localparam logic [11:0] RES_LO_ADDR  = 12'h008;
  localparam logic [11:0] STATUS_ADDR  = 12'h00C;

  // Field positions of the configuration register.
  localparam int unsigned FORMAT_BIT   = 7;
  localparam int unsigned CLKSEL_MSB   = 6;
  localparam int unsigned CLKSEL_LSB   = 4;
  localparam int unsigned REFSEL_MSB   = 1;
  localparam int unsigned REFSEL_LSB   = 0;
  localparam logic [7:0]  CONFIG_RESET = 8'h00;
  localparam logic [7:0]  CONFIG_MASK  = 8'hF3;

  // Status register bit: conversion in progress.
  localparam int unsigned BUSY_BIT     = 1;

  typedef enum logic [1:0] {
    ACR_REF_SUPPLY   = 2'h0,
    ACR_REF_RESERVED = 2'h1,
    ACR_REF_EXTERNAL = 2'h2,
    ACR_REF_FIXED    = 2'h3
  } acr_ref_type;

  typedef enum logic [1:0] {
    ACR_IDLE = 2'b00,
    ACR_BUSY = 2'b01,
    ACR_LOAD = 2'b11
  } acr_state_type;

  typedef struct packed {
    logic       format_right;
    logic [2:0] clock_select;
    logic [1:0] reference_select;
  } acr_config_type;

  typedef struct packed {
    logic [7:0] high_byte;
    logic [7:0] low_byte;
  } acr_result_type;

  // Oscillator divide ratios; zero means the dedicated RC oscillator.
  localparam logic [6:0] DIV_2  = 7'h02;
  localparam logic [6:0] DIV_4  = 7'h04;
  localparam logic [6:0] DIV_8  = 7'h08;
  localparam logic [6:0] DIV_16 = 7'h10;
  localparam logic [6:0] DIV_32 = 7'h20;
  localparam logic [6:0] DIV_64 = 7'h40;
  localparam logic [6:0] DIV_RC = 7'h00;

endpackage : acr_pkg

`default_nettype wire

// [verilog/acr_result_format.sv]
// Result layout into high and low bytes.
// Assumes a ten-bit result from the sequencer.
`default_nettype none

module acr_result_format (
  input  wire logic [9:0]          result,
  input  wire logic                format_right,
  output var acr_pkg::acr_result_type formatted
);

  always_comb begin
    if (format_right) begin
      formatted.high_byte = {6'h00, result[9:8]};
      formatted.low_byte  = result[7:0];
    end else begin
      formatted.high_byte = result[9:2];
      formatted.low_byte  = {result[1:0], 6'h00};
    end
  end

endmodule : acr_result_format

`default_nettype wire

// [verilog/acr_top.sv]
// Converter configuration and result registers behind an APB slave.
// Assumes the sequencer supplies a start, a result and a finish pulse on pclk.
//
// Summary of operation
// - Config: format bit7, clock 6-4, reference 1-0.
// - Config bits read/write, clear on reset.
// - Reference select 00 picks supply rail.
// - Select 10 picks external pin; 01 reserved.
// - Select 11 picks fixed voltage reference.
// - Left layout: high byte holds result 9-2.
// - Left layout: low byte 7-6 hold 1-0.
// - Right layout: high byte 1-0 hold 9-8.
// - Right layout: low byte holds result 7-0.
// - Result bytes writable; kept on ordinary reset.
// - Finish loads result and clears busy.
`default_nettype none

module acr_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        conv_start,
  input  wire logic        conv_done,
  input  wire logic [9:0]  conv_result,
  input  wire logic        rc_tick,
  output logic             conv_tick,
  output logic             conv_busy,
  output logic [1:0]       reference_route,
  output logic [2:0]       conversion_clock_select
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  acr_pkg::acr_config_type config_q;
  acr_pkg::acr_result_type result_q;
  acr_pkg::acr_result_type formatted;
  acr_pkg::acr_state_type  state;
  logic                    access;
  logic                    wr_en;
  logic                    mapped;
  logic [7:0]              config_byte;
  logic [31:0]             next_prdata;

  assign access = psel && penable && pready;
  assign wr_en  = access && pwrite && pstrb[0];
  assign config_byte = {config_q.format_right, config_q.clock_select, 2'b00,
                        config_q.reference_select};

  always_comb begin
    mapped      = 1'b1;
    next_prdata = 32'h0000_0000;
    case (paddr)
      acr_pkg::CONFIG_ADDR: next_prdata[7:0] = config_byte;
      acr_pkg::RES_HI_ADDR: next_prdata[7:0] = result_q.high_byte;
      acr_pkg::RES_LO_ADDR: next_prdata[7:0] = result_q.low_byte;
      acr_pkg::STATUS_ADDR: next_prdata[acr_pkg::BUSY_BIT] = conv_busy;
      default:              mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait state; read data comes from a flop loaded in the setup phase.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? next_prdata : 32'h0000_0000;
      pslverr <= psel && !penable && !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_q <= acr_pkg::acr_config_type'(6'h00);
    end else if (wr_en && paddr == acr_pkg::CONFIG_ADDR) begin
      config_q.format_right     <= pwdata[acr_pkg::FORMAT_BIT];
      config_q.clock_select     <= pwdata[acr_pkg::CLKSEL_MSB:acr_pkg::CLKSEL_LSB];
      config_q.reference_select <= pwdata[acr_pkg::REFSEL_MSB:acr_pkg::REFSEL_LSB];
    end
  end

  // The reserved code 01 is passed through; software must not write it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_route         <= acr_pkg::ACR_REF_SUPPLY;
      conversion_clock_select <= 3'h0;
    end else begin
      reference_route         <= config_q.reference_select;
      conversion_clock_select <= config_q.clock_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing and result load.

  acr_clock_divider u_divider (
    .pclk         (pclk),
    .presetn      (presetn),
    .clock_select (config_q.clock_select),
    .rc_tick      (rc_tick),
    .conv_tick    (conv_tick)
  );

  acr_result_format u_format (
    .result       (conv_result),
    .format_right (config_q.format_right),
    .formatted    (formatted)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= acr_pkg::ACR_IDLE;
      conv_busy <= 1'b0;
    end else begin
      case (state)
        acr_pkg::ACR_IDLE: begin
          if (conv_start) begin
            state     <= acr_pkg::ACR_BUSY;
            conv_busy <= 1'b1;
          end
        end
        acr_pkg::ACR_BUSY: begin
          if (conv_done) begin
            state     <= acr_pkg::ACR_LOAD;
            conv_busy <= 1'b0;
          end
        end
        acr_pkg::ACR_LOAD: state <= acr_pkg::ACR_IDLE;
        default: begin
          state     <= acr_pkg::ACR_IDLE;
          conv_busy <= 1'b0;
        end
      endcase
    end
  end

  // No reset: contents are unknown at power-up and kept across other resets.
  // A completed result wins over a software write in the same cycle.
  always_ff @(posedge pclk) begin
    if (state == acr_pkg::ACR_BUSY && conv_done) begin
      result_q <= formatted;
    end else if (wr_en && paddr == acr_pkg::RES_HI_ADDR) begin
      result_q.high_byte <= pwdata[7:0];
    end else if (wr_en && paddr == acr_pkg::RES_LO_ADDR) begin
      result_q.low_byte <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_finish;
    state == acr_pkg::ACR_BUSY && conv_done;
  endsequence

  // Checked on the bus read data, so a slip in the read mux is caught as well as one in the register.
  chk_config_zero_bits : assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite && paddr == acr_pkg::CONFIG_ADDR) |-> (prdata[3:2] == 2'b00 && prdata[31:8] == 24'h00_0000))
    else $error("unimplemented config bits not zero");

  chk_config_write : assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == acr_pkg::CONFIG_ADDR) |=> (config_byte == ($past(pwdata[7:0]) & acr_pkg::CONFIG_MASK)))
    else $error("config write not stored");

  chk_ref_route : assert property (@(posedge pclk) disable iff (!presetn)
    ##1 reference_route == $past(config_q.reference_select))
    else $error("reference route does not follow select");

  chk_left_high : assert property (@(posedge pclk) disable iff (!presetn)
    (s_finish and !config_q.format_right) |=> result_q.high_byte == $past(conv_result[9:2]))
    else $error("left high byte wrong");

  chk_left_low : assert property (@(posedge pclk) disable iff (!presetn)
    (s_finish and !config_q.format_right) |=> result_q.low_byte[7:6] == $past(conv_result[1:0]))
    else $error("left low byte wrong");

  chk_right_high : assert property (@(posedge pclk) disable iff (!presetn)
    (s_finish and config_q.format_right) |=> result_q.high_byte[1:0] == $past(conv_result[9:8]))
    else $error("right high byte wrong");

  chk_right_low : assert property (@(posedge pclk) disable iff (!presetn)
    (s_finish and config_q.format_right) |=> result_q.low_byte == $past(conv_result[7:0]))
    else $error("right low byte wrong");

  chk_busy_clear : assert property (@(posedge pclk) disable iff (!presetn)
    s_finish |=> !conv_busy ##1 state == acr_pkg::ACR_IDLE)
    else $error("busy not cleared at finish");

  chk_result_write : assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == acr_pkg::RES_HI_ADDR && !(state == acr_pkg::ACR_BUSY && conv_done))
      |=> result_q.high_byte == $past(pwdata[7:0]))
    else $error("result high write lost");

endmodule : acr_top

`default_nettype wire
